// ---- rx_header_trailer_capture.sv ----
// Receive header and trailer capture bank with its register port.
// Assumes the receive packet path runs on clk_in and presents one
// header quadlet or one trailer per strobe; the host uses the plain
// register port with read data one cycle after the read strobe.
`timescale 1ns/10ps
`include "rxcap_defines.svh"
module rx_header_trailer_capture #(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Register port
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire rxcap_pkg::quadlet_t   wr_data_in,
  input  wire logic                  wr_en_in,
  input  wire logic                  rd_en_in,
  output rxcap_pkg::quadlet_t        rd_data_out,
  // Stripped header quadlets from the receive path
  input  wire logic                  hdr_valid_in,
  input  wire logic [1:0]            hdr_index_in,
  input  wire rxcap_pkg::quadlet_t   hdr_data_in,
  // Trailer from the receive path
  input  wire logic                  trl_valid_in,
  input  wire rxcap_pkg::rx_speed_e  trl_speed_in,
  input  wire rxcap_pkg::zero_fill_e trl_fill_in,
  input  wire rxcap_pkg::ack_code_e  trl_ack_in,
  // Status toward the receive path and host logic
  output logic                       strip_enable_out,
  output logic                       hdr_complete_out
);
  import rxcap_pkg::*;

  localparam int NWORDS = 4;

  // Address decode
  wire hit_ctrl;
  wire hit_status;
  wire hit_count;
  wire hit_trailer;
  wire [NWORDS-1:0] hit_hdr;

  assign hit_ctrl    = (addr_in == ADDR_W'(`RXCAP_OFS_DMA_CTRL));
  assign hit_status  = (addr_in == ADDR_W'(`RXCAP_OFS_STATUS));
  assign hit_count   = (addr_in == ADDR_W'(`RXCAP_OFS_HDR_COUNT));
  assign hit_trailer = (addr_in == ADDR_W'(`RXCAP_OFS_TRAILER));
  assign hit_hdr[0]  = (addr_in == ADDR_W'(`RXCAP_OFS_HDR0));
  assign hit_hdr[1]  = (addr_in == ADDR_W'(`RXCAP_OFS_HDR1));
  assign hit_hdr[2]  = (addr_in == ADDR_W'(`RXCAP_OFS_HDR2));
  assign hit_hdr[3]  = (addr_in == ADDR_W'(`RXCAP_OFS_HDR3));

  wire hit_any;
  assign hit_any = hit_ctrl | hit_status | hit_count | hit_trailer
                 | (|hit_hdr);

  // Write strobes; the capture words and the trailer have none,
  // so host writes there are dropped without effect.
  wire wr_ctrl;
  wire wr_status;
  assign wr_ctrl   = wr_en_in & hit_ctrl;
  assign wr_status = wr_en_in & hit_status;

  // Control register: only the strip enable bit is implemented
  logic strip_en_reg;
  logic strip_en_next;

  assign strip_en_next = wr_ctrl ? wr_data_in[`RXCAP_BIT_STRIP_EN]
                                 : strip_en_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strip_en_reg <= 1'b0;
    end else begin
      strip_en_reg <= strip_en_next;
    end
  end

  assign strip_enable_out = strip_en_reg;

  // Header capture
  wire                  hdr_take;
  wire [NWORDS-1:0]     hdr_load;
  quadlet_t             hdr_word [NWORDS];

  // Quadlets offered while stripping is off are not stored at all
  assign hdr_take = hdr_valid_in & strip_en_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NWORDS; gi++) begin : g_hdr
      // Quadlet n of the header goes to word n
      assign hdr_load[gi] = hdr_take
                          & (hdr_index_in == 2'(gi));
      rxcap_word_reg #(
        .W     (32),
        .RESET (`RXCAP_RESET_WORD)
      ) u_hdr_word (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .load_in  (hdr_load[gi]),
        .d_in     (hdr_data_in),
        .q_out    (hdr_word[gi])
      );
    end
  endgenerate

  // Trailer capture; only the defined fields are assembled, so the
  // reserved bits of the stored word are constant zero.
  quadlet_t trl_assembled;
  quadlet_t trl_word;

  always_comb begin
    trl_assembled = `RXCAP_RESET_WORD;
    trl_assembled[`RXCAP_SPD_HI:`RXCAP_SPD_LO]   = trl_speed_in;
    trl_assembled[`RXCAP_FILL_HI:`RXCAP_FILL_LO] = trl_fill_in;
    trl_assembled[`RXCAP_ACK_HI:`RXCAP_ACK_LO]   = trl_ack_in;
  end

  rxcap_word_reg #(
    .W     (32),
    .RESET (`RXCAP_RESET_WORD)
  ) u_trl_word (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (trl_valid_in),
    .d_in     (trl_assembled & `RXCAP_TRAILER_MASK),
    .q_out    (trl_word)
  );

  // Freshness tracking so the host can tell a filled word from a
  // stale one. A word goes fresh when loaded and stale when read;
  // a load in the same cycle as the read wins.
  wire [NWORDS-1:0] hdr_read;
  wire              trl_read;
  logic [NWORDS-1:0] hdr_fresh_reg;
  logic [NWORDS-1:0] hdr_fresh_next;
  logic              trl_fresh_reg;
  logic              trl_fresh_next;

  assign hdr_read = {NWORDS{rd_en_in}} & hit_hdr;
  assign trl_read = rd_en_in & hit_trailer;

  assign hdr_fresh_next = hdr_load | (hdr_fresh_reg & ~hdr_read);
  assign trl_fresh_next = trl_valid_in | (trl_fresh_reg & ~trl_read);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hdr_fresh_reg <= '0;
      trl_fresh_reg <= 1'b0;
    end else begin
      hdr_fresh_reg <= hdr_fresh_next;
      trl_fresh_reg <= trl_fresh_next;
    end
  end

  // Overrun: a quadlet replaced a word the host had not read yet.
  // The host loses the old value; the flag is the only trace left.
  wire overrun_event;
  wire overrun_clear;
  logic overrun_reg;
  logic overrun_next;

  assign overrun_event = |(hdr_load & hdr_fresh_reg & ~hdr_read);
  assign overrun_clear = wr_status & wr_data_in[`RXCAP_ST_OVERRUN];
  assign overrun_next  = overrun_event
                       | (overrun_reg & ~overrun_clear);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= overrun_next;
    end
  end

  // Loads of header word 3 since reset; counts on the last quadlet even when words 0 to 2 were not loaded
  logic [CNT_W-1:0] hdr_count_reg;
  logic [CNT_W-1:0] hdr_count_next;

  assign hdr_count_next = hdr_load[NWORDS-1]
                        ? CNT_W'(hdr_count_reg + 1'b1)
                        : hdr_count_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hdr_count_reg <= CNT_W'(`RXCAP_RESET_COUNT);
    end else begin
      hdr_count_reg <= hdr_count_next;
    end
  end

  assign hdr_complete_out = &hdr_fresh_reg;

  // Read-back words
  quadlet_t ctrl_rd;
  quadlet_t status_rd;
  quadlet_t count_rd;

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[`RXCAP_BIT_STRIP_EN] = strip_en_reg;
  end

  always_comb begin
    status_rd = '0;
    status_rd[`RXCAP_ST_HDR_FRESH_HI:`RXCAP_ST_HDR_FRESH_LO] =
      hdr_fresh_reg;
    status_rd[`RXCAP_ST_TRL_FRESH] = trl_fresh_reg;
    status_rd[`RXCAP_ST_OVERRUN]   = overrun_reg;
  end

  assign count_rd = 32'(hdr_count_reg);

  // Read select; unmapped offsets answer zero
  wire quadlet_t rd_sel;
  assign rd_sel = ({32{hit_ctrl}}    & ctrl_rd)
                | ({32{hit_status}}  & status_rd)
                | ({32{hit_count}}   & count_rd)
                | ({32{hit_hdr[0]}}  & hdr_word[0])
                | ({32{hit_hdr[1]}}  & hdr_word[1])
                | ({32{hit_hdr[2]}}  & hdr_word[2])
                | ({32{hit_hdr[3]}}  & hdr_word[3])
                | ({32{hit_trailer}} & trl_word);

  wire quadlet_t rd_next;
  assign rd_next = (rd_en_in & hit_any) ? rd_sel : '0;

  // Read data is valid only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= rd_next;
    end
  end

endmodule

// ---- rxcap_defines.svh ----
// Register offsets, field positions and reset values for the receive
// header/trailer capture bank. Included by the capture bank only; its
// testbench uses literal values; definitions only.
`ifndef RXCAP_DEFINES_SVH
`define RXCAP_DEFINES_SVH

// Byte offsets on the register port
`define RXCAP_OFS_DMA_CTRL   8'h90
`define RXCAP_OFS_STATUS     8'h94
`define RXCAP_OFS_HDR_COUNT  8'h98
`define RXCAP_OFS_HDR0       8'hd0
`define RXCAP_OFS_HDR1       8'hd4
`define RXCAP_OFS_HDR2       8'hd8
`define RXCAP_OFS_HDR3       8'hdc
`define RXCAP_OFS_TRAILER    8'he0

// Control bit positions (bit n is data bit n)
`define RXCAP_BIT_STRIP_EN   27

// Trailer field positions
`define RXCAP_SPD_LO         14
`define RXCAP_SPD_HI         15
`define RXCAP_FILL_LO        22
`define RXCAP_FILL_HI        23
`define RXCAP_ACK_LO         28
`define RXCAP_ACK_HI         31
`define RXCAP_TRAILER_MASK   32'hf0c0_c000

// Status bit positions
`define RXCAP_ST_HDR_FRESH_LO 0
`define RXCAP_ST_HDR_FRESH_HI 3
`define RXCAP_ST_TRL_FRESH   4
`define RXCAP_ST_OVERRUN     8

// Reset values
`define RXCAP_RESET_WORD     32'h0000_0000
`define RXCAP_RESET_COUNT    16'h0000

`endif

// ---- rxcap_pkg.sv ----
// Types shared by the receive capture bank and its surroundings:
// the quadlet, and the code sets carried in the trailer.
package rxcap_pkg;

  typedef logic [31:0] quadlet_t;

  typedef enum logic [1:0] {
    speed_100  = 2'h0,
    speed_200  = 2'h1,
    speed_400  = 2'h2,
    speed_none = 2'h3
  } rx_speed_e;

  typedef enum logic [1:0] {
    fill_none  = 2'h0,
    fill_three = 2'h1,
    fill_two   = 2'h2,
    fill_one   = 2'h3
  } zero_fill_e;

  typedef enum logic [3:0] {
    ack_rsvd_0         = 4'h0,
    ack_complete       = 4'h1,
    ack_pending        = 4'h2,
    ack_rsvd_3         = 4'h3,
    ack_busy_x         = 4'h4,
    ack_busy_a         = 4'h5,
    ack_busy_b         = 4'h6,
    ack_tardy          = 4'hb,
    ack_conflict_error = 4'hc,
    ack_data_error     = 4'hd,
    ack_type_error     = 4'he,
    ack_address_error  = 4'hf
  } ack_code_e;

endpackage

// ---- rxcap_word_reg.sv ----
// One capture register with a load enable.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/10ps
module rxcap_word_reg #(
  parameter int           W     = 32,
  parameter logic [W-1:0] RESET = '0
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Load port
  input  wire logic         load_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  // No bus-reset input on purpose: only the core reset clears it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q_out <= RESET;
    end else if (load_in) begin
      q_out <= d_in;
    end
  end

endmodule

// ---- rxcap_assertions.sv ----
// Port assertions for the receive capture bank.
// Assumes one host strobe a cycle and the default 8-bit address.
`timescale 1ns/10ps
module rxcap_checker #(
  parameter int ADDR_W = 8
) (
  // Watched ports
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  input wire logic [ADDR_W-1:0]     addr_in,
  input wire rxcap_pkg::quadlet_t   wr_data_in,
  input wire logic                  wr_en_in,
  input wire logic                  rd_en_in,
  input wire rxcap_pkg::quadlet_t   rd_data_out,
  input wire logic                  hdr_valid_in,
  input wire logic [1:0]            hdr_index_in,
  input wire rxcap_pkg::quadlet_t   hdr_data_in,
  input wire logic                  trl_valid_in,
  input wire rxcap_pkg::rx_speed_e  trl_speed_in,
  input wire rxcap_pkg::zero_fill_e trl_fill_in,
  input wire rxcap_pkg::ack_code_e  trl_ack_in,
  input wire logic                  strip_enable_out,
  input wire logic                  hdr_complete_out
);
  import rxcap_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  rd_idle_a: assert property (!$past(rd_en_in) |-> rd_data_out == '0)
    else $error("read data not zero");
  strip_set_a: assert property (wr_en_in && addr_in == 8'h90 |=>
    strip_enable_out == $past(wr_data_in[27])) else $error("strip bit");
  strip_hold_a: assert property (!(wr_en_in && addr_in == 8'h90) |=>
    $stable(strip_enable_out)) else $error("strip bit moved");
  hdr_read_a: assert property ((hdr_valid_in && strip_enable_out) ##1
    (rd_en_in && !hdr_valid_in && addr_in == 8'hd0 + {$past(hdr_index_in),
    2'b00}) |=> rd_data_out == $past(hdr_data_in, 2))
    else $error("header word");
  trl_read_a: assert property (trl_valid_in ##1
    (rd_en_in && !trl_valid_in && addr_in == 8'he0) |=> rd_data_out ==
    {$past(trl_ack_in, 2), 4'h0, $past(trl_fill_in, 2), 6'h0,
    $past(trl_speed_in, 2), 14'h0}) else $error("trailer word");
  trl_rsvd_a: assert property (rd_en_in && addr_in == 8'he0 |=>
    (rd_data_out & ~32'hf0c0_c000) == '0) else $error("trailer reserved");
  cmpl_clear_a: assert property (rd_en_in && !hdr_valid_in &&
    addr_in[7:4] == 4'hd && addr_in[1:0] == 2'b00 |=> !hdr_complete_out)
    else $error("complete");
  cmpl_hold_a: assert property (!hdr_valid_in && !rd_en_in |=>
    $stable(hdr_complete_out)) else $error("complete moved");
endmodule

bind rx_header_trailer_capture rxcap_checker #(.ADDR_W(ADDR_W)) i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .hdr_valid_in(hdr_valid_in),
  .hdr_index_in(hdr_index_in), .hdr_data_in(hdr_data_in),
  .trl_valid_in(trl_valid_in), .trl_speed_in(trl_speed_in),
  .trl_fill_in(trl_fill_in), .trl_ack_in(trl_ack_in),
  .strip_enable_out(strip_enable_out), .hdr_complete_out(hdr_complete_out)
);

// ---- rxcap_host_model.sv ----
// Host model for the register port: one strobe a cycle, no waits.
// Assumes its tasks are entered right after a rising edge.
`timescale 1ns/10ps
module rxcap_host_model (
  // Clock and read data
  input  wire logic                clk_in,
  input  wire rxcap_pkg::quadlet_t rd_data_in,
  // Register port
  output logic [7:0]               addr_out,
  output rxcap_pkg::quadlet_t      wr_data_out,
  output logic                     wr_en_out,
  output logic                     rd_en_out
);
  import rxcap_pkg::*;
  initial begin
    addr_out = 8'h00;
    wr_data_out = 32'h0;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end
  // Extra edge so a following call never reassigns the strobe at once
  task automatic write_reg(input logic [7:0] a, input quadlet_t d);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    @(posedge clk_in);
  endtask
  // Data stands only in the cycle after the read edge
  task automatic read_reg(input logic [7:0] a, output quadlet_t d);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    @(posedge clk_in);
    d = rd_data_in;
  endtask
endmodule

// ---- rx_header_trailer_capture_bench.sv ----
// Self-checking bench for the receive capture bank.
// Assumes the host model and the checker bind are compiled with it.
`timescale 1ns/10ps
module rx_header_trailer_capture_bench;
  import rxcap_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [7:0] addr;
  quadlet_t   wr_data, rd_data, q;
  quadlet_t   hdr_data = '0;
  logic       wr_en, rd_en, strip_en, hdr_cmpl;
  logic       hdr_valid = 1'b0;
  logic       trl_valid = 1'b0;
  logic [1:0] hdr_index = 2'h0;
  rx_speed_e  trl_speed = speed_100;
  zero_fill_e trl_fill = fill_none;
  ack_code_e  trl_ack = ack_rsvd_0;
  int         fail_count = 0;
  int         checks = 0;

  always #5 clk_in = ~clk_in;

  rx_header_trailer_capture i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wr_data_in(wr_data), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .rd_data_out(rd_data), .hdr_valid_in(hdr_valid),
    .hdr_index_in(hdr_index), .hdr_data_in(hdr_data),
    .trl_valid_in(trl_valid), .trl_speed_in(trl_speed),
    .trl_fill_in(trl_fill), .trl_ack_in(trl_ack),
    .strip_enable_out(strip_en), .hdr_complete_out(hdr_cmpl)
  );
  rxcap_host_model i_host (
    .clk_in(clk_in), .rd_data_in(rd_data), .addr_out(addr),
    .wr_data_out(wr_data), .wr_en_out(wr_en), .rd_en_out(rd_en)
  );

  task automatic check(input quadlet_t seen, input quadlet_t exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_check(input logic [7:0] a, input quadlet_t exp);
    i_host.read_reg(a, q);
    check(q, exp);
  endtask
  task automatic send_hdr(input logic [1:0] i, input quadlet_t d);
    hdr_valid <= 1'b1;
    hdr_index <= i;
    hdr_data <= d;
    @(posedge clk_in);
  endtask

  task automatic test_reset();
    logic [7:0] ofs[6] = '{8'hd0, 8'hd4, 8'hd8, 8'hdc, 8'he0, 8'h40};
    foreach (ofs[i]) rd_check(ofs[i], 32'h0);
    check({31'h0, strip_en}, 32'h0);
    send_hdr(2'h0, 32'h1234_5678);
    hdr_valid <= 1'b0;
    i_host.write_reg(8'hd0, 32'hffff_ffff);
    rd_check(8'hd0, 32'h0);
    $display("reset test done");
  endtask

  task automatic test_capture();
    i_host.write_reg(8'h90, 32'hffff_ffff);
    check({31'h0, strip_en}, 32'h1);
    rd_check(8'h90, 32'h0800_0000);
    for (int i = 0; i < 4; i++) send_hdr(2'(i), 32'ha5a5_0000 + i);
    hdr_valid <= 1'b0;
    @(posedge clk_in);
    check({31'h0, hdr_cmpl}, 32'h1);
    for (int i = 3; i >= 0; i--) begin
      rd_check(8'hd0 + 8'(4 * i), 32'ha5a5_0000 + i);
    end
    check({31'h0, hdr_cmpl}, 32'h0);
    i_host.write_reg(8'h90, 32'h0);
    send_hdr(2'h2, 32'h5a5a_5a5a);
    hdr_valid <= 1'b0;
    rd_check(8'hd8, 32'ha5a5_0002);
    $display("capture test done");
  endtask

  task automatic test_trailer();
    ack_code_e acks[4] = '{ack_complete, ack_pending, ack_busy_x,
                           ack_rsvd_3};
    quadlet_t  exp_trl;
    for (int i = 0; i < 4; i++) begin
      trl_valid <= 1'b1;
      trl_speed <= rx_speed_e'(2'(i));
      trl_fill <= zero_fill_e'(2'(3 - i));
      trl_ack <= acks[i];
      @(posedge clk_in);
      trl_valid <= 1'b0;
      exp_trl = {acks[i], 4'h0, 2'(3 - i), 6'h0, 2'(i), 14'h0};
      rd_check(8'he0, exp_trl);
    end
    $display("trailer test done");
  endtask

  // Overrun, count and a read right behind a load, then a mid-run reset
  task automatic test_status();
    rd_check(8'h98, 32'h1);
    i_host.write_reg(8'h90, 32'h0800_0000);
    send_hdr(2'h0, 32'h1111_0000);
    send_hdr(2'h0, 32'h2222_0000);
    hdr_valid <= 1'b0;
    rd_check(8'h94, 32'h0000_0101);
    rd_check(8'hd0, 32'h2222_0000);
    i_host.write_reg(8'h94, 32'h0000_0100);
    rd_check(8'h94, 32'h0);
    send_hdr(2'h3, 32'h3333_0000);
    hdr_valid <= 1'b0;
    rd_check(8'hdc, 32'h3333_0000);
    rd_check(8'h98, 32'h2);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    check({31'h0, strip_en}, 32'h0);
    rd_check(8'hd0, 32'h0);
    rd_check(8'h98, 32'h0);
    $display("status test done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    test_reset();
    test_capture();
    test_trailer();
    test_status();
    tally_and_finish();
  end
endmodule
